// [core/etfg_pkg.sv]
// Constants, register map and state type for the E1 transmit frame generator
// Behaviour
// (R01) Setting fifo_refresh re-initialises the generator; software sets then clears it.
// (R02) Select 00 passes TS16 from data input or link controller; 01 and 10 reserved.
// (R03) Software choosing common-channel TS16 also sets extra_bits_disable to 1.
// (R04) Select 11 takes TS16 per slot; frame 0 carries 0000,X0,Y,X1,X2.
// (R05) TS16 source selection applies only while the all-ones alarm is off.
// (R06) CRC off: international bits from Si values if replacing, else passed through.
// (R07) CRC on with framing and replacement: send multiframe pattern and CRC-4 bits.
// (R08) CRC-4 of one sub-multiframe is sent in the next sub-multiframe.
// (R09) CRC on and far_block_err_disable 0: frames 13 and 15 carry FEBE.
// (R10) framing_disable 0 overwrites TS0 of alignment frames with the alignment word.
// (R11) framing_disable 1 passes data unchanged, ignoring CRC, FEBE and replace controls.
// (R12) intl_replace_disable 1 takes international bits from data input or link controller.
// (R13) Framing on, select 11: extra bits from register, or from data if disabled.
// (R14) Idle trunk sends idle code in TS1-15, TS17-31; TS16 signaling or idle.
// (R15) align_word_invert sends the inverted alignment word.
// (R16) nonalign_bit2_invert sends bit 2 of non-alignment frames as 0.
// (R17) sig_align_invert sends the signaling multiframe alignment nibble as ones.
// (R18) remote_alarm_force sends bit 3 of non-alignment frames as 1.
// (R19) mf_remote_alarm_force sends the signaling multiframe Y bit as 1.
// (R20) slot16_all_ones with framing and signaling multiframe sends ones in TS16.
// (R21) All-ones alarm sends ones in every time slot, overriding everything.
// (R22) CRC off: Si1 goes in bit 1 of alignment frames, Si0 in non-alignment.
// (R23) Extra bits X0, X1, X2 sit at TS16 bits 5, 7 and 8 of frame 0.
package etfg_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_FRAME_GEN_CFG  = 8'h40;
  localparam logic [7:0] ADDR_ALARM_DIAG_CTL = 8'h41;
  localparam logic [7:0] ADDR_INTL_BITS      = 8'h42;
  localparam logic [7:0] ADDR_EXTRA_BITS     = 8'h43;
  localparam logic [7:0] ADDR_GEN_STATUS     = 8'h4e;

  // Reset values
  localparam logic [7:0] RST_FRAME_GEN_CFG  = 8'h60;
  localparam logic [7:0] RST_ALARM_DIAG_CTL = 8'h00;
  localparam logic [7:0] RST_INTL_BITS      = 8'hc0;
  localparam logic [7:0] RST_EXTRA_BITS     = 8'h0b;

  // Writable bit masks, reserved bits read as zero
  localparam logic [7:0] MASK_INTL_BITS  = 8'hc0;
  localparam logic [7:0] MASK_EXTRA_BITS = 8'h0b;

  // Configuration register fields
  localparam int CFG_FIFO_REFRESH  = 7;
  localparam int CFG_SIG_SEL_HI    = 6;
  localparam int CFG_SIG_SEL_LO    = 5;
  localparam int CFG_CRC_GEN_ON    = 4;
  localparam int CFG_FRAMING_DIS   = 3;
  localparam int CFG_FEBE_DIS      = 2;
  localparam int CFG_INTL_REPL_DIS = 1;
  localparam int CFG_EXTRA_DIS     = 0;

  // Alarm and diagnostic register fields
  localparam int ALM_IDLE_TRUNK    = 7;
  localparam int ALM_ALIGN_INV     = 6;
  localparam int ALM_NFAS_B2_INV   = 5;
  localparam int ALM_SIG_ALIGN_INV = 4;
  localparam int ALM_REMOTE_ALARM  = 3;
  localparam int ALM_MF_REMOTE     = 2;
  localparam int ALM_TS16_ONES     = 1;
  localparam int ALM_ALL_ONES      = 0;

  // International and extra bit fields
  localparam int SI1_BIT = 7;
  localparam int SI0_BIT = 6;
  localparam int X0_BIT  = 3;
  localparam int X1_BIT  = 1;
  localparam int X2_BIT  = 0;

  // Frame structure
  localparam logic [4:0] LAST_SLOT    = 5'd31;
  localparam logic [4:0] SIG_SLOT     = 5'd16;
  localparam logic [2:0] LAST_BIT     = 3'd7;
  localparam logic [3:0] LAST_FRAME   = 4'd15;
  localparam logic [3:0] SMF2_FRAME   = 4'd8;
  localparam logic [3:0] FEBE1_FRAME  = 4'd13;
  localparam logic [3:0] FEBE2_FRAME  = 4'd15;
  localparam logic [6:0] FAS_WORD     = 7'h1b;
  localparam logic [5:0] MFAS_PATTERN = 6'h0b;
  localparam logic [3:0] CRC4_POLY    = 4'h3;

  // Generator control states, Gray coded along hold, prime, run
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b01,
    ST_PRIME = 2'b11,
    ST_RUN   = 2'b10
  } etfg_state_t;

endpackage

// [core/etfg_crc4.sv]
// Serial CRC-4 divider over one sub-multiframe
`timescale 1ns/10ps
module etfg_crc4 (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       clear,
  input  wire logic       bit_en,
  input  wire logic       restart,
  input  wire logic       bit_in,
  output logic [3:0]      crc_val
);
  import etfg_pkg::*;

  logic [3:0] seed;
  logic       fb;

  // A restart begins a new block with this bit, so no cycle is lost
  assign seed = restart ? 4'h0 : crc_val;
  assign fb   = bit_in ^ seed[3];

  // Remainder of message times x^4 divided by x^4 + x + 1
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_val <= 4'h0;
    end else if (clear) begin
      crc_val <= 4'h0;
    end else if (bit_en) begin
      crc_val <= {seed[2:0], 1'b0} ^ (fb ? CRC4_POLY : 4'h0);
    end
  end

endmodule // etfg_crc4

// [core/etfg_top.sv]
// E1 transmit frame generator: register port, frame timing and bit insertion
`timescale 1ns/10ps
module etfg_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              bit_tick,
  input  wire logic              tx_data_in,
  input  wire logic              tx_signaling_in,
  input  wire logic              link_ctrl_claim,
  input  wire logic              link_ctrl_bit,
  input  wire logic              per_channel_ctrl_enable,
  input  wire logic              per_slot_sig_source,
  input  wire logic              pcc_sig_bit,
  input  wire logic [7:0]        idle_code,
  input  wire logic [1:0]        far_block_err_in,
  output logic                   line_data_out,
  output logic                   line_bit_valid,
  output logic      [4:0]        tx_slot_num,
  output logic      [2:0]        tx_bit_num,
  output logic      [3:0]        tx_frame_num
);
  import etfg_pkg::*;

  // Software registers
  logic [7:0] cfg_r;
  logic [7:0] alm_r;
  logic [7:0] si_r;
  logic [7:0] xb_r;
  logic [7:0] rdata_nxt;

  // Frame timing
  etfg_state_t state_r;
  etfg_state_t state_nxt;
  logic [4:0]  slot_r;
  logic [2:0]  bit_r;
  logic [3:0]  frame_r;
  logic [3:0]  crc_hold_r;
  logic        out_r;
  logic        valid_r;

  // Decoded controls
  logic fifo_refresh;
  logic ts16_sig_select_hi;
  logic ts16_sig_select_lo;
  logic crc_multiframe_gen_on;
  logic framing_disable;
  logic far_block_err_disable;
  logic intl_replace_disable;
  logic extra_bits_disable;
  logic idle_trunk_force;
  logic align_word_invert;
  logic nonalign_bit2_invert;
  logic sig_align_invert;
  logic remote_alarm_force;
  logic mf_remote_alarm_force;
  logic slot16_all_ones;
  logic all_ones_alarm;

  assign fifo_refresh          = cfg_r[CFG_FIFO_REFRESH];
  assign ts16_sig_select_hi    = cfg_r[CFG_SIG_SEL_HI];
  assign ts16_sig_select_lo    = cfg_r[CFG_SIG_SEL_LO];
  assign crc_multiframe_gen_on = cfg_r[CFG_CRC_GEN_ON];
  assign framing_disable       = cfg_r[CFG_FRAMING_DIS];
  assign far_block_err_disable = cfg_r[CFG_FEBE_DIS];
  assign intl_replace_disable  = cfg_r[CFG_INTL_REPL_DIS];
  assign extra_bits_disable    = cfg_r[CFG_EXTRA_DIS];
  assign idle_trunk_force      = alm_r[ALM_IDLE_TRUNK];
  assign align_word_invert     = alm_r[ALM_ALIGN_INV];
  assign nonalign_bit2_invert  = alm_r[ALM_NFAS_B2_INV];
  assign sig_align_invert      = alm_r[ALM_SIG_ALIGN_INV];
  assign remote_alarm_force    = alm_r[ALM_REMOTE_ALARM];
  assign mf_remote_alarm_force = alm_r[ALM_MF_REMOTE];
  assign slot16_all_ones       = alm_r[ALM_TS16_ONES];
  assign all_ones_alarm        = alm_r[ALM_ALL_ONES];

  // Position decode
  logic cas_mode;
  logic is_fas;
  logic in_ts0;
  logic in_ts16;
  logic first_bit;
  logic smf_first;
  logic last_bit_of_mf;
  logic running;
  logic adv;

  assign cas_mode       = ts16_sig_select_hi & ts16_sig_select_lo;
  assign is_fas         = ~frame_r[0];
  assign in_ts0         = (slot_r == 5'd0);
  assign in_ts16        = (slot_r == SIG_SLOT);
  assign first_bit      = (bit_r == 3'd0);
  assign smf_first      = in_ts0 & first_bit & (frame_r[2:0] == 3'd0);
  assign last_bit_of_mf = (bit_r == LAST_BIT) & (slot_r == LAST_SLOT) & (frame_r == LAST_FRAME);
  assign running        = (state_r == ST_RUN);
  assign adv            = running & bit_tick;

  // Register writes; the refresh bit is plain storage, software clears it [R01]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= RST_FRAME_GEN_CFG;
      alm_r <= RST_ALARM_DIAG_CTL;
      si_r  <= RST_INTL_BITS;
      xb_r  <= RST_EXTRA_BITS;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_W'(ADDR_FRAME_GEN_CFG)) begin
        cfg_r <= reg_wdata;
      end else if (reg_addr == ADDR_W'(ADDR_ALARM_DIAG_CTL)) begin
        alm_r <= reg_wdata;
      end else if (reg_addr == ADDR_W'(ADDR_INTL_BITS)) begin
        si_r <= reg_wdata & MASK_INTL_BITS;
      end else if (reg_addr == ADDR_W'(ADDR_EXTRA_BITS)) begin
        xb_r <= reg_wdata & MASK_EXTRA_BITS;
      end
    end
  end

  // Read decode; unmapped addresses answer zero
  always_comb begin
    if (reg_addr == ADDR_W'(ADDR_FRAME_GEN_CFG)) begin
      rdata_nxt = cfg_r;
    end else if (reg_addr == ADDR_W'(ADDR_ALARM_DIAG_CTL)) begin
      rdata_nxt = alm_r;
    end else if (reg_addr == ADDR_W'(ADDR_INTL_BITS)) begin
      rdata_nxt = si_r;
    end else if (reg_addr == ADDR_W'(ADDR_EXTRA_BITS)) begin
      rdata_nxt = xb_r;
    end else if (reg_addr == ADDR_W'(ADDR_GEN_STATUS)) begin
      rdata_nxt = {1'b0, state_r, running, frame_r};
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  // Read data stands for the single cycle after the strobe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Refresh sequencing: hold while set, then start cleanly at a multiframe edge [R01]
  always_comb begin
    case (state_r)
      ST_HOLD: begin
        state_nxt = fifo_refresh ? ST_HOLD : ST_PRIME;
      end
      ST_PRIME: begin
        state_nxt = fifo_refresh ? ST_HOLD : ST_RUN;
      end
      ST_RUN: begin
        state_nxt = fifo_refresh ? ST_HOLD : ST_RUN;
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit, slot and frame counters; cleared whenever the generator is not running
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_r   <= 3'd0;
      slot_r  <= 5'd0;
      frame_r <= 4'd0;
    end else if (!running) begin
      bit_r   <= 3'd0;
      slot_r  <= 5'd0;
      frame_r <= 4'd0;
    end else if (bit_tick) begin
      bit_r <= bit_r + 3'd1;
      if (bit_r == LAST_BIT) begin
        slot_r <= (slot_r == LAST_SLOT) ? 5'd0 : slot_r + 5'd1;
        if (slot_r == LAST_SLOT) begin
          frame_r <= last_bit_of_mf ? 4'd0 : frame_r + 4'd1;
        end
      end
    end
  end

  // CRC-4 engine; C-bit positions enter the division as zero
  logic       crc_zero_pos;
  logic       crc_feed;
  logic       pre_bit;
  logic [3:0] crc_val;
  logic [3:0] crc_use;

  assign crc_zero_pos = in_ts0 & first_bit & is_fas;
  assign crc_feed     = crc_zero_pos ? 1'b0 : pre_bit;

  etfg_crc4 u_crc4 (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clear   (!running),
    .bit_en  (adv),
    .restart (smf_first),
    .bit_in  (crc_feed),
    .crc_val (crc_val)
  );

  // Remainder of the finished block goes out in the next block [R08]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_hold_r <= 4'h0;
    end else if (!running) begin
      crc_hold_r <= 4'h0;
    end else if (adv && smf_first) begin
      crc_hold_r <= crc_val; // [R08]
    end
  end

  // C1 leaves on the bit where the hold loads the finished remainder, so bypass the hold
  assign crc_use = smf_first ? crc_val : crc_hold_r;

  // International bit in TS0 bit 1
  logic intl_bit;
  logic pass_intl;

  assign pass_intl = link_ctrl_claim ? link_ctrl_bit : tx_data_in;

  always_comb begin
    intl_bit = pass_intl;
    if (intl_replace_disable) begin
      intl_bit = pass_intl; // [R12]
    end else if (!crc_multiframe_gen_on) begin
      intl_bit = is_fas ? si_r[SI1_BIT] : si_r[SI0_BIT]; // [R06] [R22]
    end else if (is_fas) begin
      intl_bit = crc_use[2'd3 - frame_r[2:1]]; // [R07] [R08]
    end else if (frame_r == FEBE1_FRAME) begin
      intl_bit = far_block_err_disable ? si_r[SI1_BIT] : ~far_block_err_in[1]; // [R09]
    end else if (frame_r == FEBE2_FRAME) begin
      intl_bit = far_block_err_disable ? si_r[SI0_BIT] : ~far_block_err_in[0]; // [R09]
    end else begin
      intl_bit = MFAS_PATTERN[3'd5 - frame_r[3:1]]; // [R07]
    end
  end

  // TS0 bits 2 to 8
  logic ts0_bit;

  always_comb begin
    ts0_bit = tx_data_in;
    if (first_bit) begin
      ts0_bit = intl_bit;
    end else if (is_fas) begin
      ts0_bit = FAS_WORD[3'd7 - bit_r] ^ align_word_invert; // [R10] [R15]
    end else if (bit_r == 3'd1) begin
      ts0_bit = ~nonalign_bit2_invert; // [R16]
    end else if (bit_r == 3'd2) begin
      ts0_bit = remote_alarm_force | tx_data_in; // [R18]
    end
  end

  // TS16 under channel-associated signaling
  logic xbit_sel;
  logic cas_bit;

  always_comb begin
    xbit_sel = 1'b0;
    cas_bit  = per_slot_sig_source ? pcc_sig_bit : tx_signaling_in; // [R04]
    if (frame_r == 4'd0) begin
      case (bit_r)
        3'd4: xbit_sel = xb_r[X0_BIT];
        3'd6: xbit_sel = xb_r[X1_BIT];
        3'd7: xbit_sel = xb_r[X2_BIT];
        default: xbit_sel = 1'b0;
      endcase
      if (bit_r < 3'd4) begin
        cas_bit = sig_align_invert; // [R04] [R17]
      end else if (bit_r == 3'd5) begin
        cas_bit = mf_remote_alarm_force; // [R19]
      end else begin
        cas_bit = extra_bits_disable ? tx_data_in : xbit_sel; // [R13] [R23]
      end
    end
  end

  // TS16 source selection [R05]
  logic ts16_bit;
  logic sig_bit;

  assign sig_bit = cas_mode ? cas_bit : tx_signaling_in;

  always_comb begin
    if (cas_mode && slot16_all_ones) begin
      ts16_bit = 1'b1; // [R20]
    end else if (cas_mode) begin
      ts16_bit = cas_bit; // [R04]
    end else if (!ts16_sig_select_hi && !ts16_sig_select_lo) begin
      ts16_bit = link_ctrl_claim ? link_ctrl_bit : tx_data_in; // [R02] [R03]
    end else begin
      ts16_bit = tx_data_in; // Reserved codes pass data [R02]
    end
  end

  // Assemble the line bit before the all-ones alarm
  logic idle_active;

  assign idle_active = idle_trunk_force & per_channel_ctrl_enable;

  always_comb begin
    if (framing_disable) begin
      pre_bit = tx_data_in; // [R11]
    end else if (in_ts0) begin
      pre_bit = ts0_bit; // [R10]
    end else if (in_ts16) begin
      if (idle_active && !(cas_mode && slot16_all_ones)) begin
        pre_bit = ts16_sig_select_hi ? sig_bit : idle_code[3'd7 - bit_r]; // [R14] [R20]
      end else begin
        pre_bit = ts16_bit;
      end
    end else if (idle_active) begin
      pre_bit = idle_code[3'd7 - bit_r]; // [R14]
    end else begin
      pre_bit = tx_data_in;
    end
  end

  // Line output; all ones while refreshing keeps the line in a known alarm state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_r   <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      valid_r <= adv;
      if (!running) begin
        out_r <= 1'b1;
      end else if (bit_tick) begin
        out_r <= all_ones_alarm ? 1'b1 : pre_bit; // [R21] [R05]
      end
    end
  end

  assign line_data_out  = out_r;
  assign line_bit_valid = valid_r;
  assign tx_slot_num    = slot_r;
  assign tx_bit_num     = bit_r;
  assign tx_frame_num   = frame_r;

endmodule // etfg_top

// [tb/etfg_props.sv]
// Line stream checks against the programmed controls
`timescale 1ns/10ps
module etfg_props
  import etfg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              line_data_out,
  input wire logic              line_bit_valid,
  input wire logic [4:0]        tx_slot_num,
  input wire logic [2:0]        tx_bit_num,
  input wire logic [3:0]        tx_frame_num,
  input wire logic              tx_data_in,
  input wire logic [1:0]        far_block_err_in
);
  logic [7:0] cfg_r, alm_r, si_r, cfg_t_r, alm_t_r, si_t_r;
  logic [4:0] slot_t_r;
  logic [2:0] bit_t_r;
  logic [3:0] frm_t_r;
  logic       dat_t_r;
  logic [1:0] fbe_t_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Shadow copies of the controls, from the register port
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= RST_FRAME_GEN_CFG;
      alm_r <= RST_ALARM_DIAG_CTL;
      si_r  <= RST_INTL_BITS;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_FRAME_GEN_CFG) cfg_r <= reg_wdata;
      if (reg_addr == ADDR_ALARM_DIAG_CTL) alm_r <= reg_wdata;
      if (reg_addr == ADDR_INTL_BITS) si_r <= reg_wdata & MASK_INTL_BITS;
    end
  end

  // Controls and inputs as of the bit now on the line
  always_ff @(posedge mclk) begin
    cfg_t_r  <= cfg_r;
    alm_t_r  <= alm_r;
    si_t_r   <= si_r;
    slot_t_r <= tx_slot_num;
    bit_t_r  <= tx_bit_num;
    frm_t_r  <= tx_frame_num;
    dat_t_r  <= tx_data_in;
    fbe_t_r  <= far_block_err_in;
  end

  // One bit may still leave as the hold takes effect, so look one cycle on
  property p_refresh;
    cfg_r[7] && cfg_t_r[7] |=> !line_bit_valid && line_data_out && tx_frame_num == 4'h0;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh not held");

  property p_fas;
    line_bit_valid && !cfg_t_r[3] && !alm_t_r[0] && !frm_t_r[0] && slot_t_r == 5'h00
      && bit_t_r != 3'h0 |-> line_data_out == (FAS_WORD[3'h7 - bit_t_r] ^ alm_t_r[6]);
  endproperty
  a_fas: assert property (p_fas) else $error("alignment word wrong");

  property p_nfas_b2;
    line_bit_valid && !cfg_t_r[3] && !alm_t_r[0] && frm_t_r[0] && slot_t_r == 5'h00
      && bit_t_r == 3'h1 |-> line_data_out == !alm_t_r[5];
  endproperty
  a_nfas_b2: assert property (p_nfas_b2) else $error("nfas bit 2 wrong");

  property p_remote;
    line_bit_valid && !cfg_t_r[3] && alm_t_r[3] && frm_t_r[0] && slot_t_r == 5'h00
      && bit_t_r == 3'h2 |-> line_data_out;
  endproperty
  a_remote: assert property (p_remote) else $error("remote alarm bit");

  property p_transp;
    line_bit_valid && cfg_t_r[3] && !alm_t_r[0] |-> line_data_out == dat_t_r;
  endproperty
  a_transp: assert property (p_transp) else $error("transparent data altered");

  property p_ones;
    line_bit_valid && alm_t_r[0] |-> line_data_out;
  endproperty
  a_ones: assert property (p_ones) else $error("all ones missing");

  property p_si;
    line_bit_valid && cfg_t_r[4:3] == 2'b00 && !cfg_t_r[1] && !alm_t_r[0]
      && slot_t_r == 5'h00 && bit_t_r == 3'h0
      |-> line_data_out == (frm_t_r[0] ? si_t_r[SI0_BIT] : si_t_r[SI1_BIT]);
  endproperty
  a_si: assert property (p_si) else $error("intl bit wrong");

  property p_febe;
    line_bit_valid && cfg_t_r[4:1] == 4'b1000 && !alm_t_r[0] && slot_t_r == 5'h00
      && bit_t_r == 3'h0 && (frm_t_r == FEBE1_FRAME || frm_t_r == FEBE2_FRAME)
      |-> line_data_out == !(frm_t_r == FEBE1_FRAME ? fbe_t_r[1] : fbe_t_r[0]);
  endproperty
  a_febe: assert property (p_febe) else $error("E bit wrong");

  property p_ts16;
    line_bit_valid && !cfg_t_r[3] && cfg_t_r[6:5] == 2'b11 && alm_t_r[1]
      && slot_t_r == SIG_SLOT |-> line_data_out;
  endproperty
  a_ts16: assert property (p_ts16) else $error("ts16 not ones");

endmodule // etfg_props

bind etfg_top etfg_props #(.ADDR_W(ADDR_W)) i_props (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .line_data_out(line_data_out),
  .line_bit_valid(line_bit_valid), .tx_slot_num(tx_slot_num), .tx_bit_num(tx_bit_num),
  .tx_frame_num(tx_frame_num), .tx_data_in(tx_data_in), .far_block_err_in(far_block_err_in));

// [tb/etfg_src_model.sv]
// Backplane transmit source: data, signaling and per-channel bits keyed to position
`timescale 1ns/10ps
module etfg_src_model (
  input  wire logic [4:0] tx_slot_num,
  input  wire logic [2:0] tx_bit_num,
  input  wire logic [3:0] tx_frame_num,
  output logic            tx_data_in,
  output logic            tx_signaling_in,
  output logic            link_ctrl_claim,
  output logic            link_ctrl_bit,
  output logic            pcc_sig_bit
);
  // Pattern varies by bit, slot and frame so a misplaced bit shows up
  assign tx_data_in      = tx_frame_num[0] ^ tx_slot_num[1] ^ tx_slot_num[3] ^ tx_bit_num[0];
  // Signaling is the inverse of data, so a wrong TS16 source is visible
  assign tx_signaling_in = ~tx_data_in;
  // Link controller never claims; its bit differs so a leak shows
  assign link_ctrl_claim = 1'b0;
  assign link_ctrl_bit   = ~tx_data_in;
  assign pcc_sig_bit     = tx_bit_num[1];
endmodule // etfg_src_model

// [tb/testbench.sv]
// Self-checking bench: register access and per-mode line checks
`timescale 1ns/10ps
module testbench;
  import etfg_pkg::*;
  logic       mclk, sys_rst, reg_wr, reg_rd, bit_tick, tx_data_in, tx_signaling_in;
  logic       link_ctrl_claim, link_ctrl_bit, pcc_sig_bit, line_data_out, line_bit_valid;
  logic       per_channel_ctrl_enable, per_slot_sig_source;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, idle_code, rd_val;
  logic [1:0] far_block_err_in;
  logic [4:0] tx_slot_num, slot_q;
  logic [2:0] tx_bit_num, bit_q;
  logic [3:0] tx_frame_num, frm_q, crc;
  logic       cap [0:15][0:31][0:7];
  int         error_cnt, n_tests, cyc;

  etfg_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_tick(bit_tick),
    .tx_data_in(tx_data_in), .tx_signaling_in(tx_signaling_in),
    .link_ctrl_claim(link_ctrl_claim), .link_ctrl_bit(link_ctrl_bit),
    .per_channel_ctrl_enable(per_channel_ctrl_enable),
    .per_slot_sig_source(per_slot_sig_source), .pcc_sig_bit(pcc_sig_bit),
    .idle_code(idle_code), .far_block_err_in(far_block_err_in),
    .line_data_out(line_data_out), .line_bit_valid(line_bit_valid),
    .tx_slot_num(tx_slot_num), .tx_bit_num(tx_bit_num), .tx_frame_num(tx_frame_num));

  etfg_src_model i_src (.tx_slot_num(tx_slot_num), .tx_bit_num(tx_bit_num),
    .tx_frame_num(tx_frame_num), .tx_data_in(tx_data_in), .tx_signaling_in(tx_signaling_in),
    .link_ctrl_claim(link_ctrl_claim), .link_ctrl_bit(link_ctrl_bit),
    .pcc_sig_bit(pcc_sig_bit));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // Cycle count, timeout, ticks idle one cycle in four
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    bit_tick <= (cyc[1:0] != 2'd3);
    if (cyc == 60000) begin
      error_cnt++;
      final_report();
    end
  end

  // Store each line bit under the position it was taken at
  always @(posedge mclk) begin
    if (line_bit_valid === 1'b1) cap[frm_q][slot_q][bit_q] <= line_data_out;
    frm_q <= tx_frame_num;
    slot_q <= tx_slot_num;
    bit_q <= tx_bit_num;
  end

  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask

  // Refresh with new controls, then capture one multiframe
  task automatic run(input logic [7:0] cfg, input logic [7:0] alm);
    wr(ADDR_ALARM_DIAG_CTL, alm);
    wr(ADDR_FRAME_GEN_CFG, cfg | 8'h80);
    wr(ADDR_FRAME_GEN_CFG, cfg);
    while (tx_frame_num !== LAST_FRAME) @(posedge mclk);
    while (tx_frame_num !== 4'h0) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask

  // Source byte at a slot, first bit in the MSB
  function automatic logic [7:0] dbyte(input logic [3:0] f, input logic [4:0] s);
    logic [7:0] r;
    for (int b = 0; b < 8; b++) r[7-b] = f[0] ^ s[1] ^ s[3] ^ b[0];
    return r;
  endfunction

  function automatic logic [7:0] cbyte(input int f, input int s);
    logic [7:0] r;
    for (int b = 0; b < 8; b++) r[7-b] = cap[f][s][b];
    return r;
  endfunction

  initial begin
    mclk = 1'b0; sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 8'h00; bit_tick = 1'b0; per_channel_ctrl_enable = 1'b0;
    per_slot_sig_source = 1'b0; idle_code = 8'ha6; far_block_err_in = 2'b10;
    error_cnt = 0; n_tests = 0; cyc = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    // Reset values, masked bits and an unmapped address
    rchk("cfg", ADDR_FRAME_GEN_CFG, 8'h60);
    rchk("alm", ADDR_ALARM_DIAG_CTL, 8'h00);
    rchk("si", ADDR_INTL_BITS, 8'hc0);
    rchk("xb", ADDR_EXTRA_BITS, 8'h0b);
    rchk("unmapped", 8'h50, 8'h00);
    wr(ADDR_INTL_BITS, 8'hff);
    rchk("si mask", ADDR_INTL_BITS, 8'hc0);
    wr(ADDR_EXTRA_BITS, 8'hff);
    rchk("xb mask", ADDR_EXTRA_BITS, 8'h0b);
    wr(ADDR_INTL_BITS, 8'h80);
    wr(ADDR_EXTRA_BITS, 8'h08);
    // CAS with programmed international and extra bits
    run(8'h60, 8'h00);
    chk("fas", cbyte(2, 0), 8'h9b);
    chk("nfas", cbyte(3, 0), {2'b01, dbyte(3, 0)[5:0]});
    chk("mf0 ts16", cbyte(0, 16), 8'h08);
    chk("cas ts16", cbyte(5, 16), ~dbyte(5, 16));
    chk("payload", cbyte(4, 7), dbyte(4, 7));
    // Diagnostic inversions and alarm bits
    run(8'h60, 8'h7c);
    chk("fas inv", cbyte(0, 0), 8'he4);
    chk("nfas alm", cbyte(1, 0), {3'b001, dbyte(1, 0)[4:0]});
    chk("mf0 inv", cbyte(0, 16), 8'hfc);
    // Extra bits from data, per-channel signaling
    per_slot_sig_source <= 1'b1;
    run(8'h61, 8'h00);
    chk("extra_bits_disable", cbyte(0, 16), dbyte(0, 16) & 8'h0b);
    chk("pcc sig", cbyte(3, 16), 8'h33);
    per_slot_sig_source <= 1'b0;
    // Common-channel TS16, extra and intl bits from data
    run(8'h03, 8'h00);
    chk("ccs f0", cbyte(0, 16), dbyte(0, 16));
    chk("ccs f9", cbyte(9, 16), dbyte(9, 16));
    chk("intl_replace_disable", cbyte(4, 0), {dbyte(4, 0)[7], FAS_WORD});
    // Framing off: all passes
    run(8'h18, 8'h00);
    chk("framing_disable ts0", cbyte(0, 0), dbyte(0, 0));
    chk("framing_disable f13", cbyte(13, 0), dbyte(13, 0));
    chk("framing_disable ts16", cbyte(0, 16), dbyte(0, 16));
    // All-ones alarm wins
    run(8'h60, 8'h01);
    chk("ais ts0", cbyte(0, 0), 8'hff);
    chk("ais ts16", cbyte(0, 16), 8'hff);
    chk("ais ts9", cbyte(6, 9), 8'hff);
    // Idle trunk with TS16 all ones
    per_channel_ctrl_enable <= 1'b1;
    run(8'h60, 8'h82);
    chk("idle ts3", cbyte(2, 3), 8'ha6);
    chk("idle ts31", cbyte(7, 31), 8'ha6);
    chk("ts16 ones", cbyte(1, 16), 8'hff);
    chk("idle fas", cbyte(2, 0), 8'h9b);
    per_channel_ctrl_enable <= 1'b0;
    // CRC-4: alignment pattern, E bits, check bits one SMF late
    run(8'h70, 8'h00);
    chk("mfas", {cap[1][0][0], cap[3][0][0], cap[5][0][0], cap[7][0][0], cap[9][0][0],
      cap[11][0][0]}, MFAS_PATTERN);
    chk("febe", {cap[13][0][0], cap[15][0][0]}, 2'b01);
    crc = 4'h0;
    for (int f = 0; f < 8; f++)
      for (int s = 0; s < 32; s++)
        for (int b = 0; b < 8; b++)
          crc = {crc[2:0], 1'b0} ^ (((s == 0 && b == 0 && f % 2 == 0) ? 1'b0 : cap[f][s][b])
            ^ crc[3] ? CRC4_POLY : 4'h0);
    chk("crc4", {cap[8][0][0], cap[10][0][0], cap[12][0][0], cap[14][0][0]}, crc);
    final_report();
  end
endmodule // testbench
